// ===== bench/mhf_phy_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// phy side: carrier and address bytes
// ----------------------------------------
module mhf_phy_model (
  input wire logic  clk,
  output logic       carrier_sense,
  output logic       rx_frame_start,
  output logic       rx_da_valid,
  output logic [7:0] rx_da_byte,
  output logic       rx_da_done
);
  initial begin
    carrier_sense  = 1'b0;
    rx_frame_start = 1'b0;
    rx_da_valid    = 1'b0;
    rx_da_byte     = 8'h00;
    rx_da_done     = 1'b0;
  end
  // carrier level change on an edge
  task automatic set_carrier(input logic on);
    @(posedge clk);
    carrier_sense <= on;
  endtask
  // one destination address, first wire byte first
  task automatic send_da(input logic [47:0] da);
    @(posedge clk);
    rx_frame_start <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      rx_frame_start <= 1'b0;
      rx_da_valid    <= 1'b1;
      rx_da_byte     <= da[47-8*i -: 8];
    end
    @(posedge clk);
    rx_da_valid <= 1'b0;
    rx_da_byte  <= ~da[7:0]; // released lane shows no stale byte
    rx_da_done  <= 1'b1;
    @(posedge clk);
    rx_da_done <= 1'b0;
  endtask
endmodule

// ===== bench/mhf_props.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module mhf_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        bit_tick,
  input wire logic        tx_ready,
  input wire logic        tx_new_attempt,
  input wire logic        tx_go,
  input wire logic        tx_abort,
  input wire logic        rx_da_done,
  input wire logic        rx_accept_en,
  input wire logic        mcast_accept,
  input wire logic        mcast_result_valid
);
  localparam int DEFER_LIM = `MHF_DEFER_LIMIT_BITS; // abort threshold
  logic [31:0] ctl_reg;  // shadow of control word
  logic [31:0] tick_reg; // bit times in this attempt
  // shadow control, count bit times since attempt start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg  <= 32'h0;
      tick_reg <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `MHF_OFS_CONTROL) ctl_reg <= reg_wdata;
      if (tx_new_attempt || !tx_ready) tick_reg <= 32'h0;
      else if (bit_tick) tick_reg <= tick_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rx_en_follows: assert property (
    reg_wr && reg_addr == `MHF_OFS_CONTROL |=> rx_accept_en == $past(reg_wdata[2]))
    else $error("rx enable not following control");
  a_tx_gated: assert property (!ctl_reg[`MHF_BIT_TX_EN] |=> !tx_go)
    else $error("transmit while disabled");
  a_no_abort_off: assert property (!ctl_reg[`MHF_BIT_DEFER_CHK] |=> !tx_abort)
    else $error("abort with check off");
  a_abort_pulse: assert property (tx_abort |=> !tx_abort)
    else $error("abort longer than one cycle");
  a_abort_late: assert property (tx_abort |-> tick_reg > DEFER_LIM)
    else $error("abort before limit");
  a_mcast_timing: assert property (mcast_result_valid |-> $past(rx_da_done))
    else $error("result not one cycle after address");
  a_mcast_pulse: assert property (mcast_result_valid |=> !mcast_result_valid)
    else $error("result longer than one cycle");
  a_pass_all: assert property (
    mcast_result_valid && ctl_reg[`MHF_BIT_PASS_MCAST] |-> mcast_accept)
    else $error("multicast refused with pass all");
endmodule
bind mhf_top mhf_props u_props (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .bit_tick,
  .tx_ready, .tx_new_attempt, .tx_go, .tx_abort, .rx_da_done, .rx_accept_en,
  .mcast_accept, .mcast_result_valid);

// ===== bench/mhf_top_tb_top.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
module mhf_top_tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ee_valid = 1'b0;
  logic [7:0]  ee_addr = 8'h0;
  logic [7:0]  ee_data = 8'h0;
  logic        ee_done = 1'b0;
  logic        bit_tick = 1'b1; // every clock is one bit time
  logic        tx_ready = 1'b0;
  logic        tx_new_attempt = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  rx_da_byte;
  logic        carrier_sense, tx_go, tx_abort, rx_frame_start, rx_da_valid, rx_da_done;
  logic        rx_accept_en, mcast_accept, mcast_result_valid;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  mhf_top uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ee_valid,
    .ee_addr, .ee_data, .ee_done, .bit_tick, .tx_ready, .tx_new_attempt, .carrier_sense,
    .tx_go, .tx_abort, .rx_frame_start, .rx_da_valid, .rx_da_byte, .rx_da_done,
    .rx_accept_en, .mcast_accept, .mcast_result_valid);
  mhf_phy_model phy (.clk, .carrier_sense, .rx_frame_start, .rx_da_valid, .rx_da_byte,
    .rx_da_done);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  // hash index of an address: crc-32 in wire order, lsb of each byte first
  function automatic logic [5:0] exp_idx(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 48; i++) begin
      if (c[0] ^ da[40 - 8 * (i / 8) + i % 8]) c = (c >> 1) ^ 32'hedb88320;
      else c = c >> 1;
    end
    return ~c[31:26];
  endfunction
  // count go and abort pulses over a span
  task automatic count(input int cyc, output int g, output int a);
    g = 0;
    a = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1 if (tx_go === 1'b1) g++;
      if (tx_abort === 1'b1) a++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(`MHF_OFS_CONTROL, 32'h0, "control_rst");
    rd(`MHF_OFS_ADDR_HIGH, 32'h0000ffff, "addr_high_rst");
    rd(`MHF_OFS_ADDR_LOW, 32'h0fffffff, "addr_low_rst");
    rd(`MHF_OFS_HASH_LOW, 32'h0, "hash_low_rst");
    rd(`MHF_OFS_HASH_HIGH, 32'h0, "hash_high_rst");
    rd(`MHF_OFS_STATUS, 32'h0, "status_rst");
    rd(4'hf, 32'h0, "unmapped");
    wr(`MHF_OFS_HASH_HIGH, 32'ha5a50f0f);
    wr(`MHF_OFS_HASH_LOW, 32'h5a5af0f0);
    rd(`MHF_OFS_HASH_HIGH, 32'ha5a50f0f, "hash_high_rw");
    rd(`MHF_OFS_HASH_LOW, 32'h5a5af0f0, "hash_low_rw");
  endtask
  task automatic t_eeprom();
    wr(`MHF_OFS_ADDR_HIGH, 32'h00001234); // dropped: load not done yet
    rd(`MHF_OFS_ADDR_HIGH, 32'h0000ffff, "addr_high_locked");
    for (int i = 1; i <= 6; i++) begin
      @(posedge clk);
      ee_valid <= 1'b1;
      ee_addr  <= i[7:0];
      ee_data  <= 8'h10 + i[7:0];
    end
    @(posedge clk);
    ee_valid <= 1'b0;
    ee_done  <= 1'b1;
    @(posedge clk);
    ee_done <= 1'b0;
    rd(`MHF_OFS_ADDR_LOW, 32'h14131211, "addr_low_ee");
    rd(`MHF_OFS_ADDR_HIGH, 32'h00001615, "addr_high_ee");
    rd(`MHF_OFS_STATUS, 32'h00000001, "status_loaded");
    wr(`MHF_OFS_ADDR_LOW, 32'hdeadbeef);
    wr(`MHF_OFS_ADDR_HIGH, 32'hffffabcd);
    rd(`MHF_OFS_ADDR_LOW, 32'hdeadbeef, "addr_low_host");
    rd(`MHF_OFS_ADDR_HIGH, 32'h0000abcd, "addr_high_host");
  endtask
  task automatic t_tx_gate();
    int g, a;
    @(posedge clk);
    tx_ready <= 1'b1;
    count(20, g, a);
    chk("go_off", g, 0);
    wr(`MHF_OFS_CONTROL, 32'h00000008);
    count(20, g, a);
    chk("go_on", g > 0, 1);
    @(posedge clk);
    tx_ready <= 1'b0;
  endtask
  task automatic t_mcast();
    logic [5:0]  idx; // index the test address must hit
    logic [63:0] tbl; // table image, high word on top
    idx = exp_idx(48'h01005e0000fb);
    for (int i = 0; i < 3; i++) begin
      wr(`MHF_OFS_HASH_HIGH, (i == 1) ? 32'hffffffff : 32'h0);
      wr(`MHF_OFS_HASH_LOW, (i == 1) ? 32'hffffffff : 32'h0);
      wr(`MHF_OFS_CONTROL, (i == 2) ? 32'h00080004 : 32'h00000004);
      phy.send_da(48'h01005e0000fb);
      #1 chk("mcast_valid", mcast_result_valid, 1);
      chk("mcast_accept", mcast_accept, i != 0);
    end
    // only the indexed bit set, then every bit but that one
    wr(`MHF_OFS_CONTROL, 32'h00000004);
    for (int i = 0; i < 2; i++) begin
      tbl = 64'h1 << idx;
      if (i == 1) tbl = ~tbl;
      wr(`MHF_OFS_HASH_HIGH, tbl[63:32]);
      wr(`MHF_OFS_HASH_LOW, tbl[31:0]);
      phy.send_da(48'h01005e0000fb);
      #1 chk("mcast_index", mcast_accept, i == 0);
    end
    chk("rx_on", rx_accept_en, 1);
    wr(`MHF_OFS_CONTROL, 32'h0);
    #1 chk("rx_off", rx_accept_en, 0);
    phy.send_da(48'h01005e0000fb);
    #1 chk("rx_off_result", mcast_result_valid, 0);
  endtask
  // restart at 20000 bit times must push the abort out
  task automatic t_defer();
    int n, g, a;
    n = 0;
    wr(`MHF_OFS_CONTROL, 32'h00000028);
    phy.set_carrier(1'b1);
    @(posedge clk);
    tx_ready <= 1'b1;
    repeat (50000) begin
      @(posedge clk);
      tx_new_attempt <= (n == 20000);
      #1 if (tx_abort === 1'b1) break;
      n++;
    end
    chk("abort_late", n >= 44289, 1);
    chk("abort_soon", n <= 44320, 1);
    @(posedge clk);
    tx_ready <= 1'b0;
    wr(`MHF_OFS_CONTROL, 32'h00000008);
    @(posedge clk);
    tx_ready <= 1'b1;
    count(26000, g, a);
    chk("abort_off", a, 0);
    chk("go_in_carrier", g, 0);
    @(posedge clk);
    tx_ready <= 1'b0;
    phy.set_carrier(1'b0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_eeprom();
    t_tx_gate();
    t_mcast();
    t_defer();
    close_out();
  end
  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    close_out();
  end
endmodule

// ===== design/mhf_crc_hash.sv
`timescale 1ns/1ps
// ----------------------------------------
// crc-32 over destination address, top six bits out
// ----------------------------------------
module mhf_crc_hash (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic      [5:0]  hash_index
);
  logic [31:0] crc_reg;  // running crc
  logic [31:0] crc_next;

  // one byte of the reflected crc-32 step
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ 32'hedb88320;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // next crc value
  always_comb begin
    crc_next = crc_reg;
    if (start) begin
      crc_next = 32'hffffffff;
    end else if (byte_valid) begin
      crc_next = crc_byte(crc_reg, byte_data);
    end
  end

  // crc register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= 32'hffffffff;
    end else begin
      crc_reg <= crc_next;
    end
  end

  // most significant six bits of the complemented final crc, order kept
  assign hash_index = ~crc_reg[31:26];
endmodule

// ===== design/mhf_top.sv
`timescale 1ns/1ps
`include "mhf_map.svh"
// Contract
// - abort after over 24288 bit times deferral
// - deferral counts only while ready and carrier
// - deferral timer restarts at zero each attempt
// - check off: defer forever, never abort
// - transmit enable gates all transmission
// - receive enable gates all reception
// - address high holds bits 47:32, rest zero
// - address low holds bits 31:0
// - power-on eeprom load of address bytes
// - eeprom bytes map to address register bytes
// - host may rewrite address after load
// - index top bit picks word, low five bit
// - multicast accepted when hash bit is one
// - pass all multicast accepts every multicast
// - hash table split high and low words
module mhf_top (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        ee_valid,
  input  wire logic [7:0]  ee_addr,
  input  wire logic [7:0]  ee_data,
  input  wire logic        ee_done,
  input  wire logic        bit_tick,
  input  wire logic        tx_ready,
  input  wire logic        tx_new_attempt,
  input  wire logic        carrier_sense,
  output logic             tx_go,
  output logic             tx_abort,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_da_valid,
  input  wire logic [7:0]  rx_da_byte,
  input  wire logic        rx_da_done,
  output logic             rx_accept_en,
  output logic             mcast_accept,
  output logic             mcast_result_valid
);
  // ----------------------------------------
  // reset release and carrier synchroniser
  // ----------------------------------------
  logic [1:0] rst_sync;       // reset release chain
  logic       rst_n;          // internal reset copy
  logic [2:0] crs_sync;       // carrier sense 3 flops

  // reset released through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // carrier from the pin, three flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crs_sync <= 3'b000;
    end else begin
      crs_sync <= {crs_sync[1:0], carrier_sense};
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [31:0]        control;
    logic [15:0]        addr_high;
    logic [31:0]        addr_low;
    logic [31:0]        hash_high;
    logic [31:0]        hash_low;
    logic               ee_loaded;
    logic               crs;
    mhf_pkg::mhf_defer_e defer_st;
    logic [14:0]        defer_cnt;
    logic               tx_go;
    logic               tx_abort;
    logic               hash_pend;
    logic               mcast;
    logic               mc_acc;
    logic               mc_val;
    logic [31:0]        rdata;
  } mhf_state_s;

  mhf_state_s st_reg;   // registered state
  mhf_state_s st_next;  // next state
  logic [5:0] hash_idx; // index from crc

  // crc engine over the destination address
  mhf_crc_hash u_crc (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (rx_frame_start),
    .byte_valid (rx_da_valid & st_reg.control[`MHF_BIT_RX_EN]),
    .byte_data  (rx_da_byte),
    .hash_index (hash_idx)
  );

  // pick one table bit from a six bit index
  function automatic logic hash_bit(input logic [5:0] idx, input logic [31:0] hi,
                                    input logic [31:0] lo);
    return idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
  endfunction

  // register read decode
  function automatic logic [31:0] read_word(input mhf_state_s s, input logic [3:0] a);
    case (a)
      `MHF_OFS_CONTROL:   return s.control;
      `MHF_OFS_ADDR_HIGH: return {16'h0000, s.addr_high};
      `MHF_OFS_ADDR_LOW:  return s.addr_low;
      `MHF_OFS_HASH_HIGH: return s.hash_high;
      `MHF_OFS_HASH_LOW:  return s.hash_low;
      `MHF_OFS_STATUS:    return {29'h00000000, s.tx_abort, s.defer_st == mhf_pkg::MHF_DEFER,
                                  s.ee_loaded};
      default:            return 32'h00000000;            // unmapped reads zero
    endcase
  endfunction

  // ----------------------------------------
  // next state logic
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.tx_go  = 1'b0;
    st_next.mc_val = 1'b0;
    st_next.rdata  = 32'h00000000;
    // carrier counts once the last two flops agree
    if (crs_sync[2] == crs_sync[1]) begin
      st_next.crs = crs_sync[2];
    end
    // eeprom load at power-on
    if (!st_reg.ee_loaded) begin
      if (ee_valid) begin
        case (ee_addr)
          8'h01:   st_next.addr_low[7:0]   = ee_data;
          8'h02:   st_next.addr_low[15:8]  = ee_data;
          8'h03:   st_next.addr_low[23:16] = ee_data;
          8'h04:   st_next.addr_low[31:24] = ee_data;
          8'h05:   st_next.addr_high[7:0]  = ee_data;
          8'h06:   st_next.addr_high[15:8] = ee_data;
          default: st_next.addr_low        = st_next.addr_low;  // outside the address
        endcase
      end
      if (ee_done) begin
        st_next.ee_loaded = 1'b1;
      end
    end
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `MHF_OFS_CONTROL: st_next.control = reg_wdata;
        `MHF_OFS_ADDR_HIGH: begin
          if (st_reg.ee_loaded) st_next.addr_high = reg_wdata[15:0];
        end
        `MHF_OFS_ADDR_LOW: begin
          if (st_reg.ee_loaded) st_next.addr_low = reg_wdata;
        end
        `MHF_OFS_HASH_HIGH: st_next.hash_high = reg_wdata;
        `MHF_OFS_HASH_LOW:  st_next.hash_low  = reg_wdata;
        default:            st_next.hash_low  = st_next.hash_low;     // ignored
      endcase
    end
    // register read, data in the next cycle only
    if (reg_rd) begin
      st_next.rdata = read_word(st_reg, reg_addr);
    end
    // deferral watch
    case (st_reg.defer_st)
      mhf_pkg::MHF_IDLE: begin
        st_next.tx_abort  = 1'b0;
        st_next.defer_cnt = 15'h0000;
        if (tx_ready && st_reg.control[`MHF_BIT_TX_EN]) begin
          if (st_reg.crs) begin
            st_next.defer_st = mhf_pkg::MHF_DEFER;
          end else begin
            st_next.tx_go = 1'b1;
          end
        end
      end
      mhf_pkg::MHF_DEFER: begin
        if (!tx_ready || !st_reg.control[`MHF_BIT_TX_EN] || tx_new_attempt) begin
          st_next.defer_st = mhf_pkg::MHF_IDLE;
        end else if (!st_reg.crs) begin
          st_next.defer_st = mhf_pkg::MHF_IDLE;            // carrier gone, retry
        end else begin
          if (bit_tick) begin
            st_next.defer_cnt = st_reg.defer_cnt + 15'h0001;
          end
          if (st_reg.control[`MHF_BIT_DEFER_CHK] &&
              st_reg.defer_cnt > 15'(`MHF_DEFER_LIMIT_BITS)) begin
            st_next.defer_st = mhf_pkg::MHF_ABORT;
            st_next.tx_abort = 1'b1;
          end else if (st_reg.defer_cnt == 15'h7fff) begin
            st_next.defer_cnt = st_reg.defer_cnt;          // saturate
          end
        end
      end
      mhf_pkg::MHF_ABORT: begin
        st_next.tx_abort = 1'b0;
        if (!tx_ready) begin
          st_next.defer_st = mhf_pkg::MHF_IDLE;
        end
      end
      default: st_next.defer_st = mhf_pkg::MHF_IDLE;
    endcase
    // multicast filter
    if (rx_frame_start) begin
      st_next.hash_pend = 1'b0;
    end
    if (rx_da_valid && !st_reg.hash_pend && st_reg.control[`MHF_BIT_RX_EN]) begin
      st_next.mcast     = rx_da_byte[0];                   // group bit of first byte
      st_next.hash_pend = 1'b1;
    end
    if (rx_da_done && st_reg.control[`MHF_BIT_RX_EN]) begin
      st_next.mc_val = st_reg.mcast;
      st_next.mc_acc = st_reg.mcast &&
                       (st_reg.control[`MHF_BIT_PASS_MCAST] ||
                        hash_bit(hash_idx, st_reg.hash_high, st_reg.hash_low));
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.control   <= `MHF_RST_CONTROL;
      st_reg.addr_high <= `MHF_RST_ADDR_HIGH;
      st_reg.addr_low  <= `MHF_RST_ADDR_LOW;
      st_reg.hash_high <= `MHF_RST_HASH;
      st_reg.hash_low  <= `MHF_RST_HASH;
      st_reg.defer_st  <= mhf_pkg::MHF_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata          = st_reg.rdata;
  assign tx_go              = st_reg.tx_go;
  assign tx_abort           = st_reg.tx_abort;
  assign rx_accept_en       = st_reg.control[`MHF_BIT_RX_EN];
  assign mcast_accept       = st_reg.mc_acc;
  assign mcast_result_valid = st_reg.mc_val;
endmodule

// ===== shared/mhf_map.svh
`ifndef MHF_MAP_SVH
`define MHF_MAP_SVH
// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define MHF_OFS_CONTROL     4'h1
`define MHF_OFS_ADDR_HIGH   4'h2
`define MHF_OFS_ADDR_LOW    4'h3
`define MHF_OFS_HASH_HIGH   4'h4
`define MHF_OFS_HASH_LOW    4'h5
`define MHF_OFS_STATUS      4'h9
// ----------------------------------------
// control field positions
// ----------------------------------------
`define MHF_BIT_PASS_MCAST  19
`define MHF_BIT_DEFER_CHK   5
`define MHF_BIT_TX_EN       3
`define MHF_BIT_RX_EN       2
// ----------------------------------------
// reset values
// ----------------------------------------
`define MHF_RST_CONTROL     32'h00000000
`define MHF_RST_ADDR_HIGH   16'hffff
`define MHF_RST_ADDR_LOW    32'h0fffffff
`define MHF_RST_HASH        32'h00000000
// ----------------------------------------
// eeprom byte addresses of the station address
// ----------------------------------------
`define MHF_EE_FIRST        8'h01
`define MHF_EE_LAST         8'h06
// ----------------------------------------
// timing: deferral limit in bit times
// ----------------------------------------
`define MHF_DEFER_LIMIT_BITS 24288
`endif

// ===== shared/mhf_pkg.sv
package mhf_pkg;
  // deferral watch states, gray along idle -> defer -> abort
  typedef enum logic [1:0] {
    MHF_IDLE  = 2'b00,
    MHF_DEFER = 2'b01,
    MHF_ABORT = 2'b11
  } mhf_defer_e;
endpackage
